// >>> design/vih_flag_bank.sv
// vih_flag_bank: one pending flag per source, set wins over clear
// assumes: set/clear are one-cycle strobes on sys_clk_i
`timescale 1ns/10ps
module vih_flag_bank #(
  parameter int          NUM_SRC = vih_pkg::N_SRC,
  parameter logic [21:0] MASK    = vih_pkg::SRC_VALID
) (
  input  wire logic               sys_clk_i,
  input  wire logic               reset_i,
  input  wire logic [NUM_SRC-1:0] set_i,
  input  wire logic [NUM_SRC-1:0] clr_i,
  input  wire logic [NUM_SRC-1:0] follow_i,
  input  wire logic [NUM_SRC-1:0] follow_val_i,
  output logic      [NUM_SRC-1:0] flag_o
);

  typedef struct packed {
    logic [NUM_SRC-1:0] flag;
  } vih_fb_state_t;

  vih_fb_state_t st_r;
  vih_fb_state_t st_nxt;

  // per bit: follow a level, or latch an event until cleared
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (follow_i[i]) begin
        st_nxt.flag[i] = follow_val_i[i];
      end else begin
        // set beats a clear in the same cycle
        st_nxt.flag[i] = set_i[i] | (st_r.flag[i] & ~clr_i[i]);
      end
      st_nxt.flag[i] = st_nxt.flag[i] & MASK[i];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_o = st_r.flag;

  default clocking fb_cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  set_wins_a: assert property (
    (set_i & ~follow_i & MASK[NUM_SRC-1:0]) != '0 |=>
      (flag_o & $past(set_i & ~follow_i & MASK[NUM_SRC-1:0]))
        == $past(set_i & ~follow_i & MASK[NUM_SRC-1:0]))
    else $error("flag set lost");

endmodule

// >>> design/vih_handler.sv
// vih_handler: two-level vectored interrupt handler, 22 sources
// assumes: core strobes insn_done_i at each instruction end,
// return_from_interrupt_done_i at the end of a return, and runs the long call itself
`timescale 1ns/10ps
module vih_handler (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // peripheral valid-condition strobes, primary and second flag
  input  wire logic [21:0] periph_event_i,
  input  wire logic [21:0] aux_event_i,
  // software writes to the pending flags
  input  wire logic [21:0] sw_set_i,
  input  wire logic [21:0] sw_clr_i,
  input  wire logic [21:0] sw_aux_set_i,
  input  wire logic [21:0] sw_aux_clr_i,
  // enable and level configuration
  input  wire logic [21:0] src_enable_i,
  input  wire logic [21:0] src_level_i,
  input  wire logic        global_irq_enable_i,
  input  wire logic        ext0_trigger_type_i,
  input  wire logic        ext1_trigger_type_i,
  // active-low request pins
  input  wire logic        ext_request_pin_0_n_i,
  input  wire logic        ext_request_pin_1_n_i,
  input  wire logic [3:0]  ext_request_pin_hi_n_i,
  // core sequencer strobes
  input  wire logic        insn_done_i,
  input  wire logic        return_from_interrupt_done_i,
  // to the core
  output logic             call_req_o,
  output logic [15:0]      call_vector_o,
  output logic [4:0]       call_src_o,
  // status
  output logic [21:0]      pending_flags_o,
  output logic [21:0]      aux_flags_o,
  output logic             in_service_hi_o,
  output logic             in_service_lo_o
);

  localparam int N  = vih_pkg::N_SRC;
  localparam int IW = vih_pkg::ID_W;
  localparam int VW = vih_pkg::VEC_W;

  typedef struct packed {
    logic [1:0]    pin01_prev;
    logic [3:0]    pinhi_prev;
    logic          svc_hi;
    logic          svc_lo;
    logic          req_valid;
    logic          req_hi;
    logic [IW-1:0] req_id;
    logic [VW-1:0] vector;
  } vih_state_t;

  vih_state_t st_r;
  vih_state_t st_nxt;

  logic [N-1:0]  evt;
  logic [N-1:0]  hw_clr;
  logic [N-1:0]  follow;
  logic [N-1:0]  follow_val;
  logic [N-1:0]  flags;
  logic [N-1:0]  aux;
  logic [N-1:0]  req;
  logic [N-1:0]  hi_req;
  logic [N-1:0]  lo_req;
  logic [IW:0]   hi_pick;
  logic [IW:0]   lo_pick;
  logic          take;
  logic          edge0;
  logic          edge1;
  logic [3:0]    fall_hi;

  // lowest index wins among set bits: {found, id}
  function automatic logic [IW:0] pick_first(input logic [N-1:0] m);
    logic [IW:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = {1'b1, IW'(i)};
      end
    end
    return r;
  endfunction

  // vector address of a source in fixed order
  function automatic logic [VW-1:0] vec_of(input logic [IW-1:0] id);
    return vih_pkg::VEC_BASE + VW'(vih_pkg::VEC_STEP * VW'(id));
  endfunction

  // pin edge detection and trigger type selection
  always_comb begin
    edge0 = (ext0_trigger_type_i == vih_pkg::TRIG_EDGE);
    edge1 = (ext1_trigger_type_i == vih_pkg::TRIG_EDGE);
    fall_hi = st_r.pinhi_prev & ~ext_request_pin_hi_n_i;
    evt = periph_event_i | sw_set_i;
    evt[vih_pkg::SRC_EXT0] = evt[vih_pkg::SRC_EXT0] |
      (st_r.pin01_prev[0] & ~ext_request_pin_0_n_i);
    evt[vih_pkg::SRC_EXT1] = evt[vih_pkg::SRC_EXT1] |
      (st_r.pin01_prev[1] & ~ext_request_pin_1_n_i);
    for (int k = 0; k < vih_pkg::EXT_HI; k++) begin
      evt[vih_pkg::SRC_EXT4 + k] = evt[vih_pkg::SRC_EXT4 + k] |
        fall_hi[k];
    end
    // level mode: flag mirrors the pin, requester must hold it
    follow = '0;
    follow_val = '0;
    follow[vih_pkg::SRC_EXT0] = ~edge0;
    follow[vih_pkg::SRC_EXT1] = ~edge1;
    follow_val[vih_pkg::SRC_EXT0] = ~ext_request_pin_0_n_i;
    follow_val[vih_pkg::SRC_EXT1] = ~ext_request_pin_1_n_i;
  end

  // hardware clear only for edge-mode ext 0/1 on the taken call;
  // every other latched flag stays set until software clears it; level-mode ext 0/1 follow the pin
  always_comb begin
    hw_clr = sw_clr_i;
    if (take && st_r.req_id == IW'(vih_pkg::SRC_EXT0) && edge0) begin
      hw_clr[vih_pkg::SRC_EXT0] = 1'b1;
    end
    if (take && st_r.req_id == IW'(vih_pkg::SRC_EXT1) && edge1) begin
      hw_clr[vih_pkg::SRC_EXT1] = 1'b1;
    end
  end

  vih_flag_bank #(
    .NUM_SRC (N),
    .MASK    (vih_pkg::SRC_VALID)
  ) u_primary (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .set_i        (evt),
    .clr_i        (hw_clr),
    .follow_i     (follow),
    .follow_val_i (follow_val),
    .flag_o       (flags)
  );

  // second flag of sources whose several flags share one vector
  vih_flag_bank #(
    .NUM_SRC (N),
    .MASK    (vih_pkg::AUX_MASK)
  ) u_aux (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .set_i        (aux_event_i | sw_aux_set_i),
    .clr_i        (sw_aux_clr_i),
    .follow_i     ('0),
    .follow_val_i ('0),
    .flag_o       (aux)
  );

  // gating and two-pass arbitration, sampled every clock
  always_comb begin
    req = (flags | aux) & src_enable_i & vih_pkg::SRC_VALID;
    req = req & {N{global_irq_enable_i}};
    hi_req = req & src_level_i;
    lo_req = req & ~src_level_i;
    hi_pick = pick_first(hi_req);
    lo_pick = pick_first(lo_req);
  end

  // call is refused in the very cycle a return ends, so at least
  // one more instruction boundary passes first
  assign call_req_o = st_r.req_valid & ~return_from_interrupt_done_i;
  assign take = insn_done_i & call_req_o;

  // next-state: request register, service levels, pin history
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin01_prev = {ext_request_pin_1_n_i, ext_request_pin_0_n_i};
    st_nxt.pinhi_prev = ext_request_pin_hi_n_i;
    st_nxt.req_valid = 1'b0;
    st_nxt.req_hi = 1'b0;
    // high may preempt low; nothing preempts high
    if (hi_pick[IW] && !st_r.svc_hi) begin
      st_nxt.req_valid = 1'b1;
      st_nxt.req_hi = 1'b1;
      st_nxt.req_id = hi_pick[IW-1:0];
    end else if (lo_pick[IW] && !st_r.svc_hi && !st_r.svc_lo) begin
      st_nxt.req_valid = 1'b1;
      st_nxt.req_id = lo_pick[IW-1:0];
    end
    // a taken request is dropped for one sample so it cannot be
    // taken twice from the stale register
    if (take) begin
      st_nxt.req_valid = 1'b0;
    end
    st_nxt.vector = vec_of(st_nxt.req_id);
    // level stack: entering marks the level, return pops the top
    if (take) begin
      if (st_r.req_hi) begin
        st_nxt.svc_hi = 1'b1;
      end else begin
        st_nxt.svc_lo = 1'b1;
      end
    end else if (return_from_interrupt_done_i) begin
      if (st_r.svc_hi) begin
        st_nxt.svc_hi = 1'b0;
      end else begin
        st_nxt.svc_lo = 1'b0;
      end
    end
  end

  // state register; pins rest at their idle high level
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r.pin01_prev <= vih_pkg::PIN01_IDLE;
      st_r.pinhi_prev <= vih_pkg::PINHI_IDLE;
      st_r.svc_hi     <= 1'b0;
      st_r.svc_lo     <= 1'b0;
      st_r.req_valid  <= 1'b0;
      st_r.req_hi     <= 1'b0;
      st_r.req_id     <= '0;
      st_r.vector     <= vih_pkg::VEC_BASE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign call_vector_o   = st_r.vector;
  assign call_src_o      = st_r.req_id;
  assign pending_flags_o = flags;
  assign aux_flags_o     = aux;
  assign in_service_hi_o = st_r.svc_hi;
  assign in_service_lo_o = st_r.svc_lo;

  // checks, all in the system clock domain
  default clocking hd_cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_take;
    insn_done_i && call_req_o;
  endsequence

  sequence s_take_hi;
    insn_done_i && call_req_o && st_r.req_hi;
  endsequence

  sequence s_idle_pending;
    !st_r.svc_hi && !st_r.svc_lo && global_irq_enable_i &&
      ((flags | aux) & src_enable_i & vih_pkg::SRC_VALID) != '0 &&
      !(insn_done_i && call_req_o);
  endsequence

  no_call_return_from_interrupt_a: assert property (
    return_from_interrupt_done_i |-> !call_req_o)
    else $error("call offered at return boundary");

  global_gate_a: assert property (
    !global_irq_enable_i |=> !st_r.req_valid)
    else $error("request with global enable off");

  hi_no_preempt_a: assert property (
    in_service_hi_o |=> !call_req_o)
    else $error("high routine preempted");

  lo_wait_a: assert property (
    in_service_lo_o && !in_service_hi_o |=> !call_req_o || st_r.req_hi)
    else $error("low request during low routine");

  vector_map_a: assert property (
    call_req_o |-> call_vector_o == vec_of(call_src_o) &&
      call_vector_o <= vih_pkg::VEC_LAST &&
      call_vector_o != vih_pkg::VEC_UNUSED)
    else $error("bad vector");

  enter_level_a: assert property (
    s_take_hi |=> in_service_hi_o)
    else $error("high level not marked");

  take_drop_a: assert property (
    s_take |=> !call_req_o ##1 (in_service_hi_o || in_service_lo_o))
    else $error("taken request not retired");

  detect_a: assert property (
    s_idle_pending |=> st_r.req_valid)
    else $error("pending request not detected in one cycle");

  level_track_a: assert property (
    ext0_trigger_type_i != vih_pkg::TRIG_EDGE |=>
      pending_flags_o[vih_pkg::SRC_EXT0] == !$past(ext_request_pin_0_n_i))
    else $error("level flag not tracking pin");

  edge_clear_a: assert property (
    s_take ##0 (call_src_o == IW'(vih_pkg::SRC_EXT0) && edge0 &&
      !sw_set_i[vih_pkg::SRC_EXT0] && !periph_event_i[vih_pkg::SRC_EXT0] &&
      !(st_r.pin01_prev[0] && !ext_request_pin_0_n_i)) |=>
      !pending_flags_o[vih_pkg::SRC_EXT0])
    else $error("edge flag not cleared on call");

  hi_first_a: assert property (
    st_r.req_valid && !st_r.req_hi && $past(hi_req != '0) |->
      $past(st_r.svc_hi))
    else $error("low won over eligible high");

endmodule

// >>> pkg/vih_pkg.sv
// vih_pkg: constants for the two-level vectored interrupt handler
// assumes: single system clock, core sequencer drives boundary strobes
package vih_pkg;

  // source count and widths
  localparam int N_SRC  = 22;
  localparam int ID_W   = 5;
  localparam int VEC_W  = 16;
  localparam int EXT_HI = 4;

  // vector layout
  localparam logic [15:0] RESET_VEC  = 16'h0000;
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam logic [15:0] VEC_STEP   = 16'h0008;
  localparam logic [15:0] VEC_LAST   = 16'h00ab;
  localparam logic [15:0] VEC_UNUSED = 16'h00a3;

  // source indices in fixed order
  localparam int SRC_EXT0   = 0;
  localparam int SRC_EXT1   = 2;
  localparam int SRC_EXT4   = 16;
  localparam int SRC_UNUSED = 20;

  // sources that can request at all (slot 20 is empty)
  localparam logic [21:0] SRC_VALID = 22'h2fffff;
  // sources that own a second flag sharing the vector
  localparam logic [21:0] AUX_MASK  = 22'h000250;

  // pin idle level (active-low pins rest high)
  localparam logic [1:0] PIN01_IDLE = 2'h3;
  localparam logic [3:0] PINHI_IDLE = 4'hf;
  // trigger type value that selects edge mode
  localparam logic TRIG_EDGE = 1'b1;

  // response timing in system clock cycles (5 ns each)
  localparam int CLK_PERIOD_NS = 5;
  localparam int DETECT_CYC    = 1;
  localparam int CALL_CYC      = 4;
  localparam int RETURN_FROM_INTERRUPT_CYC      = 5;
  localparam int DIV_CYC       = 8;
  localparam int MIN_RESP_CYC  = DETECT_CYC + CALL_CYC;
  localparam int MAX_RESP_CYC  = DETECT_CYC + RETURN_FROM_INTERRUPT_CYC + DIV_CYC + CALL_CYC;

endpackage

// >>> verification/test_vih_handler.sv
// test_vih_handler: self-checking bench for the interrupt handler
// assumes: vih_core_model plays the core; bench plays the peripherals
`timescale 1ns/10ps
module test_vih_handler;
  logic        sys_clk, rst, gen, slow, insn, return_from_interrupt, req, took, hi, lo;
  logic [21:0] ev, ax, sset, sclr, saclr, saset, en, lvl, pend, auxf, exp_f;
  logic [1:0]  p01, t01;
  logic [3:0]  phi;
  logic [15:0] vec;
  logic [4:0]  src;
  int          fails, cmp_count, since, seed, n;

  vih_handler vih_handler_inst (
    .sys_clk_i(sys_clk), .reset_i(rst), .periph_event_i(ev),
    .aux_event_i(ax), .sw_set_i(sset), .sw_clr_i(sclr),
    .sw_aux_set_i(saset), .sw_aux_clr_i(saclr),
    .src_enable_i(en), .src_level_i(lvl), .global_irq_enable_i(gen),
    .ext0_trigger_type_i(t01[0]), .ext1_trigger_type_i(t01[1]),
    .ext_request_pin_0_n_i(p01[0]), .ext_request_pin_1_n_i(p01[1]),
    .ext_request_pin_hi_n_i(phi), .insn_done_i(insn), .return_from_interrupt_done_i(return_from_interrupt),
    .call_req_o(req), .call_vector_o(vec), .call_src_o(src),
    .pending_flags_o(pend), .aux_flags_o(auxf),
    .in_service_hi_o(hi), .in_service_lo_o(lo));

  vih_core_model vih_core_model_inst (
    .sys_clk_i(sys_clk), .reset_i(rst), .call_req_i(req),
    .slow_i(slow), .insn_done_o(insn), .return_from_interrupt_done_o(return_from_interrupt));

  always #2.5 sys_clk = ~sys_clk;

  // takes, and instruction ends counted since the last return
  always @(posedge sys_clk) begin
    took <= insn & req;
    if (return_from_interrupt) since <= 0;
    else if (insn) since <= since + 1;
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  task automatic end_sim;
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded waits; a hang counts as a mismatch
  task automatic take_wait;
    n = 0;
    while (took !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(n < 100, 1, "no take");
  endtask

  task automatic idle;
    n = 0;
    while ((hi | lo) !== 1'b0 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(n < 300, 1, "never idle");
  endtask

  task automatic serve(input int s, input logic clr);
    n = 0;
    while (req !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    chk(src, s, "source");
    chk(vec, vih_pkg::VEC_BASE + vih_pkg::VEC_STEP * s, "vector");
    take_wait();
    chk(hi, lvl[s], "level in service");
    if (clr) begin
      sclr[s] = 1'b1;
      cyc(1);
      sclr = '0;
    end
  endtask

  // software set must call after one flag cycle and one request cycle
  task automatic fire(input int s);
    sset[s] = 1'b1;
    cyc(1);
    sset = '0;
    chk(req, 0, "early request");
    cyc(1);
    chk(req, 1, "late request");
    serve(s, 1'b1);
    idle();
  endtask

  initial begin
    #(5 * 40000);
    fails++;
    end_sim();
  end

  initial begin
    {sys_clk, gen, slow, ev, ax, sset, sclr, saclr, saset, en, lvl} = '0;
    {fails, cmp_count, since} = '0;
    seed = 32'hdcca727a;
    rst = 1'b1;
    p01 = 2'h3;
    phi = 4'hf;
    t01 = 2'h3;
    cyc(12);
    rst = 1'b0;
    chk({req, vec}, 17'h00003, "reset outputs");
    chk({pend, hi, lo}, 0, "reset flags");
    gen = 1'b1;
    en = '1;
    // every vector slot except empty slot 20, alternating levels
    for (int s = 0; s < 22; s++) begin
      lvl[s] = s[0];
      if (s != 20) fire(s);
    end
    lvl = '0;
    sset[20] = 1'b1; // empty slot never requests
    cyc(1);
    sset = '0;
    cyc(3);
    chk({pend[20], req}, 0, "slot 20");
    // disabled flag sets but stays silent; global gate
    en[5] = 1'b0;
    sset[5] = 1'b1;
    cyc(1);
    sset = '0;
    gen = 1'b0;
    cyc(3);
    chk({pend[5], req}, 2'h2, "disabled source");
    en[5] = 1'b1;
    cyc(4);
    chk(req, 0, "global off");
    gen = 1'b1;
    serve(5, 1'b1);
    idle();
    // same level: lower order wins; high level beats order
    sset[7] = 1'b1;
    sset[3] = 1'b1;
    lvl[9] = 1'b1;
    cyc(1);
    sset = '0;
    serve(3, 1'b1);
    sset[9] = 1'b1;
    sset[1] = 1'b1;
    cyc(1);
    sset = '0;
    serve(9, 1'b1);
    serve(1, 1'b1);
    serve(7, 1'b1);
    idle();
    // preemption of a slow low routine, then blocked equal level
    slow = 1'b1;
    lvl = 22'h005000;
    fire(3);
    sset[3] = 1'b1;
    cyc(1);
    sset = '0;
    serve(3, 1'b1);
    sset[12] = 1'b1;
    cyc(1);
    sset = '0;
    serve(12, 1'b1);
    chk(lo, 1, "low kept");
    sset[14] = 1'b1;
    cyc(1);
    sset = '0;
    cyc(4);
    chk(req, 0, "equal level waits");
    serve(14, 1'b1);
    n = 0;
    while (hi !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(lo, 1, "low restored");
    idle();
    // flag left set: re-entry after exactly one instruction
    sset[5] = 1'b1;
    cyc(1);
    sset = '0;
    serve(5, 1'b0);
    cyc(1);
    take_wait();
    chk(since, 1, "one insn after return");
    chk(src, 5, "re-entry");
    sclr[5] = 1'b1;
    cyc(1);
    sclr = '0;
    idle();
    slow = 1'b0;
    lvl = '0;
    // ext 0/1: edge flag cleared on take; level flag follows pin
    for (int i = 0; i < 2; i++) begin
      p01[i] = 1'b0;
      cyc(2);
      chk(pend[2*i], 1, "edge flag");
      serve(2 * i, 1'b0);
      chk(pend[2*i], 0, "edge cleared");
      p01[i] = 1'b1;
      idle();
      t01[i] = 1'b0;
      p01[i] = 1'b0; // held until recognised
      serve(2 * i, 1'b0);
      p01[i] = 1'b1; // released inside the routine
      cyc(2);
      chk(pend[2*i], 0, "level follows pin");
      idle();
      chk(req, 0, "no extra request");
    end
    // ext 4..7 falling edges keep their flags
    for (int k = 0; k < 4; k++) begin
      phi[k] = 1'b0;
      cyc(2);
      serve(16 + k, 1'b0);
      chk(pend[16+k], 1, "edge 4-7 flag kept");
      sclr[16+k] = 1'b1;
      cyc(1);
      sclr = '0;
      phi[k] = 1'b1;
      idle();
    end
    // second flag shares the source vector
    ax[4] = 1'b1;
    cyc(1);
    ax = '0;
    chk(auxf, 22'h000010, "second flag");
    serve(4, 1'b0);
    saclr[4] = 1'b1;
    cyc(1);
    saclr = '0;
    idle();
    // software write of a second flag calls like an event
    saset[9] = 1'b1;
    cyc(1);
    saset = '0;
    chk(auxf, 22'h000200, "sw second flag");
    serve(9, 1'b0);
    saclr[9] = 1'b1;
    cyc(1);
    saclr = '0;
    idle();
    // random events with global off; flags set regardless
    gen = 1'b0;
    exp_f = '0;
    for (int i = 0; i < 300; i++) begin
      ev = 22'($random(seed)) & 22'h3ffffa;
      sclr = 22'($random(seed)) & 22'($random(seed));
      en = 22'($random(seed));
      exp_f = (exp_f | ev) & ~(sclr & ~ev) & vih_pkg::SRC_VALID;
      cyc(1);
      chk(pend, exp_f, "random flags");
      chk(req, 0, "random no call");
    end
    end_sim();
  end
endmodule

// >>> verification/vih_core_model.sv
// vih_core_model: behavioural core sequencer facing the handler
// assumes: handler offers calls on call_req_i; strobes move at negedge
`timescale 1ns/10ps
module vih_core_model (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic call_req_i,
  input  wire logic slow_i,
  output logic      insn_done_o,
  output logic      return_from_interrupt_done_o
);
  int   left;
  int   depth;
  int   body [0:7];
  logic take;
  logic rst_seen;
  logic ins_nx;
  logic ret_nx;

  // a take is an instruction end while a call is offered; reset is
  // sampled here so the negedge process never races the bench
  always @(posedge sys_clk_i) begin
    take     <= insn_done_o & call_req_i & ~reset_i;
    rst_seen <= reset_i;
  end

  // one strobe per instruction end; each isr body ends in a return
  always @(negedge sys_clk_i) begin
    ins_nx = 1'b0;
    ret_nx = 1'b0;
    if (rst_seen) begin
      left = 1;
      depth = 0;
    end else if (take) begin
      depth = depth + 1;
      body[depth] = slow_i ? 4 : 1;
      left = slow_i ? 6 : 4; // no strobe in the 4-cycle long call
    end else begin
      left = left - 1;
      if (left == 0) begin
        if (depth > 0 && body[depth] == 0) begin
          ret_nx = 1'b1; // return resumes outer stream
          depth = depth - 1;
        end else begin
          ins_nx = 1'b1;
          if (depth > 0) body[depth] = body[depth] - 1;
        end
        // a return takes five cycles
        left = (depth > 0 && body[depth] == 0) ? 5 : (slow_i ? 3 : 1);
      end
    end
    // each strobe is written once per edge, no zero-time glitch
    insn_done_o <= ins_nx;
    return_from_interrupt_done_o <= ret_nx;
  end
endmodule
